/* verilog/dsd_pkg.sv */
// Purpose: Shared constants and types of the DDR device front end.
// Assumes: One 10 MHz core clock; each DDR slot pair is one clock's worth.
// Notes: Mode register fields follow the base and extended load words.
package dsd_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int REFRESH_WINDOW_MS = 64;
	localparam int REFRESH_ROWS = 8192;
	// Longest gap between refreshes, rounded down to whole cycles
	localparam int REFRESH_GAP_CYC = REFRESH_WINDOW_MS * 1000000 / CLK_PERIOD_NS / REFRESH_ROWS;
	localparam logic [6:0] REFRESH_GAP_LAST = 7'(REFRESH_GAP_CYC - 1);
	localparam logic [7:0] DLL_LOCK_LAST = 8'd199;
	// ==========================================================
	// Widths and layout
	localparam int ADDR_W = 13;
	localparam int DQ_W = 16;
	localparam int COL_W = 5;
	localparam int FIFO_W = 32;
	localparam int FIFO_DEPTH = 32;
	localparam int AUTO_CLOSE_BIT = 10;
	localparam int BL_LSB = 0;
	localparam int BURST_TYPE_BIT = 3;
	localparam int LAT_LSB = 4;
	localparam int DLL_RESET_BIT = 8;
	localparam int DLL_DISABLE_BIT = 0;
	localparam logic [1:0] MODE_SEL_BASE = 2'h0;
	localparam logic [1:0] MODE_SEL_EXT = 2'h1;
	// ==========================================================
	// Mode codes and reset values
	localparam logic [2:0] BL2 = 3'h1;
	localparam logic [2:0] BL4 = 3'h2;
	localparam logic [2:0] BL8 = 3'h3;
	localparam logic [2:0] LAT_2 = 3'h2;
	localparam logic [2:0] LAT_3 = 3'h3;
	localparam logic [2:0] LAT_4 = 3'h4;
	localparam logic [2:0] LAT_2H = 3'h6;
	localparam logic [12:0] BASE_MODE_RST = 13'h0021;
	localparam logic [12:0] EXT_MODE_RST = 13'h0000;
	// ==========================================================
	// Command code is the row, column and write strobe levels
	typedef enum logic [2:0] {
		CMD_LOAD = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010, CMD_ACT = 3'b011,
		CMD_WR = 3'b100, CMD_RD = 3'b101, CMD_STOP = 3'b110, CMD_NOP = 3'b111
	} dsd_cmd_t;
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00, PWR_PRE_DOWN = 2'b01, PWR_ACT_DOWN = 2'b10
	} dsd_pwr_t;
endpackage

/* verilog/dsd_fifo.sv */
// Purpose: Read data buffer between array fetch and output slots.
// Assumes: Single clock; en freezes all state.
// Notes: Output word comes from a register loaded ahead of the pop.
`timescale 1ns/1ps
module dsd_fifo
	import dsd_pkg::*;
#(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic push;
	logic load;

	// ==========================================================
	// Handshake; full counts storage only, output stage is extra
	assign inReady = count < (AW+1)'(DEPTH);
	assign push = en && inValid && inReady;
	assign load = en && (count != '0) && (!outValid || outReady);

	// Storage array, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (load) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
		end
	end

	// Registered output stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outValid <= 1'b0;
			outData <= '0;
		end else if (load) begin
			outValid <= 1'b1;
			outData <= mem[rdPtr];
		end else if (en && outReady) begin
			outValid <= 1'b0;
		end
	end
endmodule

/* verilog/dsd_ddr_device.sv */
// Purpose: Command, bank, power and double-rate data front end of a DRAM.
// Assumes: Pins arrive synchronous to clk; each clock carries a rise and fall slot.
// Notes: Array is a small model indexed by bank and low column bits only.
`timescale 1ns/1ps
// Functional notes
// - Commands and addresses are taken only at the rising clock edge.
// - Write data, strobes and masks are taken in both slots of a clock.
// - Each internal column access fetches two beats: rise and fall.
// - Read latency 2, 2.5, 3 or 4 clocks; controller expects it.
// - Burst of 2, 4 or 8 beats, sequential or interleaved order.
// - Bank select picks the bank of activate, read, write, precharge.
// - Auto and self refresh; controller gives 8192 refreshes per 64 ms.
// - Clock enable low enters precharge, active power-down or self refresh.
// - Power-down synchronous; self refresh exit and output off asynchronous.
// - Power-down and self refresh ignore command and data inputs.
// - Chip select high masks every command.
// - A delay-locked loop model only raises a lock flag; read data and strobe slots do not depend on it.
// - Read data edge-aligned with strobe; write data centred by controller.
// - Wide part has separate low and high byte strobes.
// - Write mask is sampled in both slots, one bit per beat.
// - Read beats go out in both half periods of the clock.
// - Precharge closes one bank, or all when the close flag is high.
// - A masked beat is not stored; low and high mask per byte.
// - Row, column, write strobes with chip select form the command.
// - Mode load picks base or extended register by bank select.
module dsd_ddr_device
	import dsd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic cke,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [1:0] bankSel,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DQ_W-1:0] dqInRise,
	input wire logic [DQ_W-1:0] dqInFall,
	input wire logic [1:0] lowStrobeIn,
	input wire logic [1:0] highStrobeIn,
	input wire logic [1:0] lowByteMask,
	input wire logic [1:0] highByteMask,
	output logic [DQ_W-1:0] dqOutRise,
	output logic [DQ_W-1:0] dqOutFall,
	output logic dqRiseOeN,
	output logic dqFallOeN,
	output logic [1:0] lowStrobeOut,
	output logic [1:0] highStrobeOut,
	output logic [3:0] bankOpen,
	output dsd_pwr_t powerState,
	output logic selfRefresh,
	output logic dllLocked,
	output logic [15:0] refreshCount
);
	logic ckePrev;
	dsd_cmd_t cmd;
	logic live;
	logic isLoad, isRef, isPre, isAct, isWrite, isRead, isStop;
	logic pdEntry, srEntry;
	logic [12:0] baseMode;
	logic [12:0] extMode;
	logic [2:0] blCode, latCode;
	logic interleave, latHalf;
	logic [1:0] lastPair, dueSlot;
	logic [4:0] colMask;
	logic [6:0] srTimer;
	logic [7:0] dllCount;
	logic rdActive;
	logic [1:0] rdBank, rdPair;
	logic [4:0] rdStart;
	logic [1:0] pushBank, pushPair;
	logic [4:0] pushStart;
	logic pushValid, fifoInReady, pushAdv, readDone;
	logic [FIFO_W-1:0] pushData, fifoOut;
	logic fifoOutValid, popNow;
	logic [3:0] dueShift;
	logic [DQ_W-1:0] heldFall;
	logic heldValid, riseDrive;
	logic wrActive, writeLive;
	logic [1:0] wrBank, wrPair;
	logic [4:0] wrStart;
	logic [6:0] wrRiseIdx, wrFallIdx;
	logic [DQ_W-1:0] cells [128];

	// ==========================================================
	// Command capture
	// Previous clock enable qualifies every command at the rising edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ckePrev <= 1'b0;
		end else if (en) begin
			ckePrev <= cke;
		end
	end

	// Commands count only with chip select low and inputs awake
	assign cmd = dsd_cmd_t'({rasN, casN, weN});
	assign live = en && cke && ckePrev && !csN && !selfRefresh && powerState == PWR_RUN;
	assign isLoad = live && cmd == CMD_LOAD;
	assign isRef = live && cmd == CMD_REF;
	assign isPre = live && cmd == CMD_PRE;
	assign isAct = live && cmd == CMD_ACT;
	assign isWrite = live && cmd == CMD_WR;
	assign isRead = live && cmd == CMD_RD;
	assign isStop = live && cmd == CMD_STOP;

	// ==========================================================
	// Mode registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baseMode <= BASE_MODE_RST;
			extMode <= EXT_MODE_RST;
		end else if (isLoad) begin
			if (bankSel == MODE_SEL_BASE) begin
				baseMode <= addr;
			end else if (bankSel == MODE_SEL_EXT) begin
				extMode <= addr;
			end
		end
	end

	// Decoded burst and latency; odd codes fall back to the shortest choice
	assign blCode = baseMode[BL_LSB +: 3];
	assign latCode = baseMode[LAT_LSB +: 3];
	assign interleave = baseMode[BURST_TYPE_BIT];
	assign latHalf = latCode == LAT_2H;
	always_comb begin
		unique case (blCode)
			BL4: begin lastPair = 2'h1; colMask = 5'h03; end
			BL8: begin lastPair = 2'h3; colMask = 5'h07; end
			default: begin lastPair = 2'h0; colMask = 5'h01; end
		endcase
	end
	// Slot in the due line is latency minus the fifo stage
	always_comb begin
		unique case (latCode)
			LAT_3: dueSlot = 2'h2;
			LAT_4: dueSlot = 2'h3;
			default: dueSlot = 2'h1;
		endcase
	end

	// Column of one beat in its burst block; mode bits are arguments so indices follow a mode load
	function automatic logic [4:0] beatCol(input logic [4:0] start, input logic [2:0] beat,
		input logic il, input logic [4:0] mask);
		logic [4:0] off;
		off = il ? (start ^ {2'b00, beat}) : 5'(start + {2'b00, beat});
		beatCol = (start & ~mask) | (off & mask);
	endfunction

	// ==========================================================
	// Bank state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bankOpen <= 4'h0;
		end else if (isAct) begin
			bankOpen[bankSel] <= 1'b1;
		end else if (isPre) begin
			if (addr[AUTO_CLOSE_BIT]) begin
				bankOpen <= 4'h0;
			end else begin
				bankOpen[bankSel] <= 1'b0;
			end
		end else if ((isRead || isWrite) && addr[AUTO_CLOSE_BIT]) begin
			bankOpen[bankSel] <= 1'b0;
		end
	end

	// ==========================================================
	// Power control
	assign srEntry = en && ckePrev && !cke && !csN && cmd == CMD_REF && bankOpen == 4'h0
		&& powerState == PWR_RUN && !selfRefresh;
	assign pdEntry = en && ckePrev && !cke && powerState == PWR_RUN && !selfRefresh && !srEntry;

	// Power-down enters and leaves only on a clock edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			powerState <= PWR_RUN;
		end else if (en) begin
			unique case (powerState)
				PWR_RUN: begin
					if (pdEntry) begin
						powerState <= (|bankOpen) ? PWR_ACT_DOWN : PWR_PRE_DOWN;
					end
				end
				PWR_PRE_DOWN, PWR_ACT_DOWN: begin
					if (cke) begin
						powerState <= PWR_RUN;
					end
				end
				default: powerState <= PWR_RUN;
			endcase
		end
	end

	// Self refresh leaves as soon as clock enable rises, clock or not
	always_ff @(posedge clk or negedge rst_n or posedge cke) begin
		if (!rst_n) begin
			selfRefresh <= 1'b0;
		end else if (cke) begin
			selfRefresh <= 1'b0;
		end else if (srEntry) begin
			selfRefresh <= 1'b1;
		end
	end

	// Refresh count: commanded refreshes plus internal self refresh ticks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srTimer <= 7'h00;
			refreshCount <= 16'h0000;
		end else if (en) begin
			srTimer <= (selfRefresh && srTimer != REFRESH_GAP_LAST) ? srTimer + 7'h01 : 7'h00;
			if (isRef || (selfRefresh && srTimer == REFRESH_GAP_LAST)) begin
				refreshCount <= refreshCount + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Output alignment loop model
	// Read launch is already on clock slots; the lock flag only tells software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dllCount <= 8'h00;
			dllLocked <= 1'b0;
		end else if (en) begin
			if (isLoad && bankSel == MODE_SEL_BASE && addr[DLL_RESET_BIT]) begin
				dllCount <= 8'h00;
				dllLocked <= 1'b0;
			end else if (extMode[DLL_DISABLE_BIT]) begin
				dllLocked <= 1'b0;
			end else if (dllCount == DLL_LOCK_LAST) begin
				dllLocked <= 1'b1;
			end else begin
				dllCount <= dllCount + 8'h01;
			end
		end
	end

	// ==========================================================
	// Read fetch: pair zero goes on the command edge itself
	assign pushValid = en && (isRead || rdActive);
	assign pushBank = isRead ? bankSel : rdBank;
	assign pushStart = isRead ? addr[COL_W-1:0] : rdStart;
	assign pushPair = isRead ? 2'h0 : rdPair;
	assign pushData = {
		cells[{pushBank, beatCol(pushStart, {pushPair, 1'b0}, interleave, colMask)}],
		cells[{pushBank, beatCol(pushStart, {pushPair, 1'b1}, interleave, colMask)}]};
	assign pushAdv = pushValid && fifoInReady;
	assign readDone = pushAdv && pushPair == lastPair;

	// Burst walker; a full buffer stalls the fetch rather than drop beats
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdActive <= 1'b0;
			rdBank <= 2'h0;
			rdStart <= 5'h00;
			rdPair <= 2'h0;
		end else if (en) begin
			if (isRead) begin
				rdBank <= bankSel;
				rdStart <= addr[COL_W-1:0];
				rdPair <= pushAdv ? 2'h1 : 2'h0;
				rdActive <= !readDone;
			end else if (isStop || isWrite) begin
				rdActive <= 1'b0;
			end else if (pushAdv) begin
				rdPair <= rdPair + 2'h1;
				rdActive <= !readDone;
			end
		end
	end

	dsd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) readBuf (
		.clk(clk),
		.rst_n(rst_n),
		.en(en),
		.inValid(pushValid),
		.inReady(fifoInReady),
		.inData(pushData),
		.outValid(fifoOutValid),
		.outReady(dueShift[0] && en),
		.outData(fifoOut)
	);

	// Due line: each fetched pair is owed to the pins latency clocks later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dueShift <= 4'h0;
		end else if (en) begin
			dueShift <= {1'b0, dueShift[3:1]} | (pushAdv ? (4'h1 << dueSlot) : 4'h0);
		end
	end

	// ==========================================================
	// Read output slots
	assign popNow = en && dueShift[0] && fifoOutValid;
	assign riseDrive = popNow ? (!latHalf || heldValid) : heldValid;

	// Half latency shifts every beat one slot, leaving a tail rise beat
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dqOutRise <= '0;
			dqOutFall <= '0;
			heldFall <= '0;
			heldValid <= 1'b0;
			lowStrobeOut <= 2'b00;
			highStrobeOut <= 2'b00;
		end else if (en) begin
			if (popNow && latHalf) begin
				dqOutRise <= heldFall;
				dqOutFall <= fifoOut[FIFO_W-1 -: DQ_W];
				heldFall <= fifoOut[DQ_W-1:0];
			end else if (popNow) begin
				dqOutRise <= fifoOut[FIFO_W-1 -: DQ_W];
				dqOutFall <= fifoOut[DQ_W-1:0];
			end else if (heldValid) begin
				dqOutRise <= heldFall;
			end
			heldValid <= popNow && latHalf;
			// Strobe high in the rise slot, low in the fall slot: edge aligned
			lowStrobeOut <= {riseDrive, 1'b0};
			highStrobeOut <= {riseDrive, 1'b0};
		end
	end

	// Drivers turn off at once when clock enable drops
	always_ff @(posedge clk or negedge rst_n or negedge cke) begin
		if (!rst_n) begin
			dqRiseOeN <= 1'b1;
			dqFallOeN <= 1'b1;
		end else if (!cke) begin
			dqRiseOeN <= 1'b1;
			dqFallOeN <= 1'b1;
		end else if (en) begin
			dqRiseOeN <= !riseDrive;
			dqFallOeN <= !popNow;
		end
	end

	// ==========================================================
	// Write capture
	assign writeLive = en && wrActive && cke;
	assign wrRiseIdx = {wrBank, beatCol(wrStart, {wrPair, 1'b0}, interleave, colMask)};
	assign wrFallIdx = {wrBank, beatCol(wrStart, {wrPair, 1'b1}, interleave, colMask)};

	// Write bursts take one beat pair per clock after the command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrActive <= 1'b0;
			wrBank <= 2'h0;
			wrStart <= 5'h00;
			wrPair <= 2'h0;
		end else if (en) begin
			if (isWrite) begin
				wrActive <= 1'b1;
				wrBank <= bankSel;
				wrStart <= addr[COL_W-1:0];
				wrPair <= 2'h0;
			end else if (isRead || isStop) begin
				wrActive <= 1'b0;
			end else if (writeLive) begin
				wrPair <= wrPair + 2'h1;
				wrActive <= wrPair != lastPair;
			end
		end
	end

	// Each byte lane needs its own strobe and an unset mask in that slot
	always_ff @(posedge clk) begin
		if (writeLive) begin
			if (lowStrobeIn[1] && !lowByteMask[1]) begin
				cells[wrRiseIdx][7:0] <= dqInRise[7:0];
			end
			if (highStrobeIn[1] && !highByteMask[1]) begin
				cells[wrRiseIdx][15:8] <= dqInRise[15:8];
			end
			if (lowStrobeIn[0] && !lowByteMask[0]) begin
				cells[wrFallIdx][7:0] <= dqInFall[7:0];
			end
			if (highStrobeIn[0] && !highByteMask[0]) begin
				cells[wrFallIdx][15:8] <= dqInFall[15:8];
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	cs_mask_a: assert property (en && csN && powerState == PWR_RUN |=> $stable(bankOpen))
		else $error("command taken with chip select high");
	act_open_a: assert property (isAct |=> bankOpen[$past(bankSel)])
		else $error("activate did not open bank");
	pre_all_a: assert property (isPre && addr[AUTO_CLOSE_BIT] |=> bankOpen == 4'h0)
		else $error("precharge all left a bank open");
	lat3_a: assert property (isRead && latCode == LAT_3 && dueShift == 4'h0 && dqFallOeN
		|=> dqFallOeN [*3] ##1 !dqFallOeN)
		else $error("read data not at latency three");
	bl8_a: assert property (isRead && blCode == BL8 && latCode == LAT_2 && dueShift == 4'h0
		##1 !(isRead || isWrite || isStop) [*4] |-> (!dqFallOeN) [*3] ##1 dqFallOeN)
		else $error("burst of eight not four pairs");
	pd_entry_a: assert property (pdEntry && |bankOpen |=> powerState == PWR_ACT_DOWN)
		else $error("active power-down not entered");
	sr_exit_a: assert property (cke |-> !selfRefresh)
		else $error("self refresh held with clock enable high");
	oe_off_a: assert property (!cke |-> dqRiseOeN && dqFallOeN)
		else $error("outputs driven with clock enable low");
	pd_frozen_a: assert property (powerState != PWR_RUN && !cke |=> $stable(bankOpen))
		else $error("command seen in power-down");
	ref_count_a: assert property (isRef |=> refreshCount == $past(refreshCount) + 16'h0001)
		else $error("refresh not counted");

	read_c: cover property (isRead ##[1:8] !dqFallOeN);
	write_c: cover property (isWrite ##1 writeLive);
	self_c: cover property (srEntry ##1 selfRefresh ##[1:100] !selfRefresh);
	half_c: cover property (popNow && latHalf ##1 heldValid);
endmodule

/* tb/dsd_host_model.sv */
// Purpose: Controller model driving commands and write pairs.
// Assumes: Pins change only just after a rising edge.
// Notes: Released data lines invert each cycle, so stale data never passes.
`timescale 1ns/1ps
module dsd_host_model
	import dsd_pkg::*;
(
	input wire logic clk,
	output logic cke,
	output logic csN,
	output logic rasN,
	output logic casN,
	output logic weN,
	output logic [1:0] bankSel,
	output logic [ADDR_W-1:0] addr,
	output logic [DQ_W-1:0] dqInRise,
	output logic [DQ_W-1:0] dqInFall,
	output logic [1:0] lowStrobeIn,
	output logic [1:0] highStrobeIn,
	output logic [1:0] lowByteMask,
	output logic [1:0] highByteMask
);
	// ========
	// Time zero: deselected, clock enable low
	initial begin
		{cke, csN, rasN, casN, weN} = 5'h0f;
		{bankSel, addr} = 15'h0000;
		{dqInRise, dqInFall} = 32'h0000ffff;
		{lowStrobeIn, highStrobeIn, lowByteMask, highByteMask} = 8'h0f;
	end
	// ========
	// One command per edge; bank is always valid with it
	task automatic cmd(input dsd_cmd_t c, input logic [1:0] b, input logic [ADDR_W-1:0] a,
		input logic k, input logic s);
		@(posedge clk);
		cke <= k;
		csN <= s;
		{rasN, casN, weN} <= c;
		bankSel <= b;
		addr <= a;
		{dqInRise, dqInFall} <= ~{dqInRise, dqInFall};
		{lowStrobeIn, highStrobeIn, lowByteMask, highByteMask} <= 8'h0f;
	endtask
	// Write pair under a nop; clock enable stays high through the burst
	task automatic pair(input logic [DQ_W-1:0] r, input logic [DQ_W-1:0] f,
		input logic [7:0] sm);
		@(posedge clk);
		cke <= 1'b1;
		csN <= 1'b0;
		{rasN, casN, weN} <= CMD_NOP;
		{dqInRise, dqInFall} <= {r, f};
		{lowStrobeIn, highStrobeIn, lowByteMask, highByteMask} <= sm;
	endtask
endmodule

/* tb/test_dsd_ddr_device.sv */
// Purpose: Self-checking bench of the DDR device front end.
// Assumes: Host model drives pins; read beats are noted per slot.
// Notes: Buffer back-pressure is left unexercised.
`timescale 1ns/1ps
module test_dsd_ddr_device
	import dsd_pkg::*;
();
	typedef struct {int c; logic [DQ_W-1:0] d;} dsd_beat_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cke, csN, rasN, casN, weN, dqRiseOeN, dqFallOeN, selfRefresh, dllLocked;
	logic [1:0] bankSel, lowStrobeIn, highStrobeIn, lowByteMask, highByteMask;
	logic [1:0] lowStrobeOut, highStrobeOut;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0] dqInRise, dqInFall, dqOutRise, dqOutFall;
	logic [3:0] bankOpen;
	logic [15:0] refreshCount;
	dsd_pwr_t powerState;
	logic [DQ_W-1:0] mem [8];
	logic [2:0] lats [3] = '{LAT_2, LAT_3, LAT_4};
	dsd_beat_t riseQ[$];
	dsd_beat_t fallQ[$];
	dsd_beat_t w;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	// ========
	// Clock and edge count
	always #50 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	dsd_ddr_device DUT (.clk(clk), .rst_n(rst_n), .en(1'b1), .cke(cke), .csN(csN),
		.rasN(rasN), .casN(casN), .weN(weN), .bankSel(bankSel), .addr(addr),
		.dqInRise(dqInRise), .dqInFall(dqInFall), .lowStrobeIn(lowStrobeIn),
		.highStrobeIn(highStrobeIn), .lowByteMask(lowByteMask), .highByteMask(highByteMask),
		.dqOutRise(dqOutRise), .dqOutFall(dqOutFall), .dqRiseOeN(dqRiseOeN),
		.dqFallOeN(dqFallOeN), .lowStrobeOut(lowStrobeOut), .highStrobeOut(highStrobeOut),
		.bankOpen(bankOpen), .powerState(powerState), .selfRefresh(selfRefresh),
		.dllLocked(dllLocked), .refreshCount(refreshCount));
	dsd_host_model HOST (.clk(clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
		.weN(weN), .bankSel(bankSel), .addr(addr), .dqInRise(dqInRise), .dqInFall(dqInFall),
		.lowStrobeIn(lowStrobeIn), .highStrobeIn(highStrobeIn), .lowByteMask(lowByteMask),
		.highByteMask(highByteMask));
	// ========
	// Shared compare and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		compares++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask
	task automatic test_done();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ========
	// Each driven slot takes the oldest note; the cycle stamp checks latency
	always @(negedge clk) begin
		if (dqRiseOeN === 1'b0) begin
			w = '{-1, 16'h0000};
			if (riseQ.size() > 0) w = riseQ.pop_front();
			check(cyc, w.c, "rise slot cycle");
			check(dqOutRise, w.d, "rise beat");
			check(lowStrobeOut, 2'h2, "low strobe");
			check(highStrobeOut, 2'h2, "high strobe");
		end
		if (dqFallOeN === 1'b0) begin
			w = '{-1, 16'h0000};
			if (fallQ.size() > 0) w = fallQ.pop_front();
			check(cyc, w.c, "fall slot cycle");
			check(dqOutFall, w.d, "fall beat");
		end
	end
	// ========
	// Stimulus helpers; a wait before checking lets the answer edge land
	task automatic nop(input int n, input logic k = 1'b1);
		repeat (n) HOST.cmd(CMD_NOP, 2'h0, 13'h0000, k, 1'b0);
	endtask
	task automatic step(input logic k);
		nop(2, k);
		@(negedge clk);
	endtask
	// Extended load follows each base load and must not disturb it
	task automatic mode(input logic [2:0] lat, input logic il, input logic [2:0] bl);
		HOST.cmd(CMD_LOAD, MODE_SEL_BASE, ADDR_W'({lat, il, bl}), 1'b1, 1'b0);
		HOST.cmd(CMD_LOAD, MODE_SEL_EXT, 13'h0070, 1'b1, 1'b0);
		nop(1);
	endtask
	function automatic void upd(input int a, input logic [DQ_W-1:0] v, input logic lo,
		input logic hi);
		if (lo) mem[a][7:0] = v[7:0];
		if (hi) mem[a][15:8] = v[15:8];
	endfunction
	// Burst write to bank 1; sm packs strobes then masks of both lanes
	task automatic wr(input int col, input int n, input logic [7:0] sm);
		logic [DQ_W-1:0] r, f;
		HOST.cmd(CMD_WR, 2'h1, ADDR_W'(col), 1'b1, 1'b0);
		for (int k = 0; k < n; k++) begin
			r = DQ_W'($urandom);
			f = DQ_W'($urandom);
			HOST.pair(r, f, sm);
			upd(col + 2 * k, r, sm[7] & ~sm[3], sm[5] & ~sm[1]);
			upd(col + 2 * k + 1, f, sm[6] & ~sm[2], sm[4] & ~sm[0]);
		end
	endtask
	// Read of bank 1; each beat is noted with the edge its slot must show
	task automatic rd(input int col, input int lat, input int n, input bit il, input bit hf = 1'b0);
		int c0;
		int a;
		dsd_beat_t b;
		HOST.cmd(CMD_RD, 2'h1, ADDR_W'(col), 1'b1, 1'b0);
		c0 = cyc + 2;
		for (int i = 0; i < 2 * n; i++) begin
			a = il ? (col ^ i) : ((col & ~(2 * n - 1)) | ((col + i) & (2 * n - 1)));
			// Half a clock of extra latency moves every beat one slot later
			b = '{c0 + lat + (i + hf) / 2, mem[a]};
			if ((i + hf) % 2 == 0) riseQ.push_back(b);
			else fallQ.push_back(b);
		end
		nop(n + lat + 2);
	endtask
	// ========
	// Main sequence
	initial begin
		void'($urandom(37));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 400 && dllLocked !== 1'b1; i++) nop(1);
		check(dllLocked, 1'b1, "delay loop lock");
		if (dllLocked !== 1'b1) test_done();
		HOST.cmd(CMD_ACT, 2'h1, 13'h0000, 1'b1, 1'b1);
		step(1'b1);
		check(bankOpen, 4'h0, "deselected activate");
		HOST.cmd(CMD_ACT, 2'h3, 13'h0000, 1'b1, 1'b0);
		HOST.cmd(CMD_ACT, 2'h1, 13'h0000, 1'b1, 1'b0);
		step(1'b1);
		check(bankOpen, 4'ha, "two banks open");
		HOST.cmd(CMD_PRE, 2'h3, 13'h0000, 1'b1, 1'b0);
		step(1'b1);
		check(bankOpen, 4'h2, "one bank closed");
		// Full burst, then partial lanes: fall low unstrobed, rise high masked
		mode(LAT_2, 1'b0, BL8);
		wr(0, 4, 8'hf0);
		mode(LAT_2, 1'b0, BL4);
		wr(4, 2, 8'hb2);
		foreach (lats[i]) begin
			mode(lats[i], 1'b0, BL4);
			rd(6, i + 2, 2, 1'b0);
			mode(lats[i], 1'b1, BL8);
			rd(5, i + 2, 4, 1'b1);
		end
		mode(LAT_2H, 1'b0, BL4);
		rd(6, 2, 2, 1'b0, 1'b1);
		mode(LAT_2, 1'b0, BL2);
		rd(3, 2, 1, 1'b0);
		HOST.cmd(CMD_PRE, 2'h0, 13'h0400, 1'b1, 1'b0);
		step(1'b1);
		check(bankOpen, 4'h0, "all banks closed");
		HOST.cmd(CMD_REF, 2'h0, 13'h0000, 1'b1, 1'b0);
		HOST.cmd(CMD_REF, 2'h0, 13'h0000, 1'b1, 1'b0);
		step(1'b1);
		check(refreshCount, 16'h0002, "auto refresh count");
		HOST.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
		step(1'b0);
		check(powerState, PWR_PRE_DOWN, "idle power-down");
		HOST.cmd(CMD_ACT, 2'h2, 13'h0000, 1'b0, 1'b0);
		step(1'b0);
		check(bankOpen, 4'h0, "command while asleep");
		nop(1);
		step(1'b1);
		check(powerState, PWR_RUN, "power-down exit");
		HOST.cmd(CMD_ACT, 2'h1, 13'h0000, 1'b1, 1'b0);
		HOST.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
		step(1'b0);
		check(powerState, PWR_ACT_DOWN, "active power-down");
		nop(1);
		step(1'b1);
		HOST.cmd(CMD_PRE, 2'h0, 13'h0400, 1'b1, 1'b0);
		HOST.cmd(CMD_REF, 2'h0, 13'h0000, 1'b0, 1'b0);
		step(1'b0);
		check(selfRefresh, 1'b1, "self refresh entry");
		nop(90, 1'b0);
		@(negedge clk);
		check(refreshCount > 16'h0002, 1'b1, "self refresh ticks");
		HOST.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1, 1'b0);
		@(negedge clk);
		check(selfRefresh, 1'b0, "clockless wake");
		nop(4);
		check(riseQ.size() + fallQ.size(), 0, "beats never shown");
		test_done();
	end
	// Hang guard
	initial begin
		#2000000;
		check(0, 1, "run timeout");
		test_done();
	end
endmodule
